// ### common/bst_cfg.svh
// Constants of the boundary-scan test access port.
`ifndef BST_CFG_SVH
`define BST_CFG_SVH

// Instruction register layout and codes.
`define BST_IR_W 4
`define BST_IR_CAPT 4'h1
`define BST_OP_EXTEST 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDCODE 4'h2
`define BST_OP_HIGHZ 4'h4
`define BST_OP_BYPASS 4'hF
`define BST_IR_RST `BST_OP_IDCODE

// Identification register layout.
`define BST_ID_W 32
`define BST_ID_VER_LSB 28
`define BST_ID_PART_LSB 12
`define BST_ID_MAKER_LSB 1

// Default boundary chain length.
`define BST_BSR_LEN 8

`endif

// ### common/bst_pkg.sv
// Types shared by the boundary-scan test access port files.
package bst_pkg;

  // TAP controller states with their usual codes.
  typedef enum logic [3:0] {
    BST_TLR  = 4'b1111,
    BST_RTI  = 4'b1100,
    BST_SDR  = 4'b0111,
    BST_CDR  = 4'b0110,
    BST_SHDR = 4'b0010,
    BST_E1DR = 4'b0001,
    BST_PDR  = 4'b0011,
    BST_E2DR = 4'b0000,
    BST_UDR  = 4'b0101,
    BST_SIR  = 4'b0100,
    BST_CIR  = 4'b1110,
    BST_SHIR = 4'b1010,
    BST_E1IR = 4'b1001,
    BST_PIR  = 4'b1011,
    BST_E2IR = 4'b1000,
    BST_UIR  = 4'b1101
  } bst_state_type;

  // Data register chosen by the active instruction.
  typedef enum logic [1:0] {
    BST_DR_BYP = 2'b00,
    BST_DR_BSR = 2'b01,
    BST_DR_ID  = 2'b10
  } bst_dr_type;

endpackage : bst_pkg

// ### rtl/bst_bsr_chain.sv
// Boundary-scan cell chain: capture, shift and update stages.
`timescale 1ns/1ns
`include "bst_cfg.svh"
module bst_bsr_chain #(
  parameter int LEN = `BST_BSR_LEN
) (
  input  wire logic           tck_i,      // Test clock.
  input  wire logic           trst_n_i,   // Test reset, active low.
  input  wire logic           capture_i,  // Capture-DR with chain selected.
  input  wire logic           shift_i,    // Shift-DR with chain selected.
  input  wire logic           update_i,   // Update-DR with chain selected.
  input  wire logic           tdi_i,      // Serial input.
  input  wire logic [LEN-1:0] pin_in_i,   // Port values, other domain.
  output logic                so_o,       // Serial output of the chain.
  output logic      [LEN-1:0] upd_o       // Update latches.
);

  // Shift side state on the rising test clock.
  typedef struct packed {
    logic [LEN-1:0] s1;
    logic [LEN-1:0] s2;
    logic [LEN-1:0] sh;
  } bst_cell_type;

  bst_cell_type   cell_r;
  bst_cell_type   cell_nxt;
  logic [LEN-1:0] upd_r;
  logic [LEN-1:0] sh_w;

  // ********************
  // Per-cell next value
  // ********************
  // Cell LEN-1 is nearest the serial input; cell 0 feeds the output.
  for (genvar i = 0; i < LEN; i++) begin : g_cell
    logic src;
    assign src     = (i == LEN - 1) ? tdi_i : cell_r.sh[(i + 1) % LEN];
    assign sh_w[i] = capture_i ? cell_r.s2[i] : (shift_i ? src : cell_r.sh[i]);
  end

  // Port values pass two flops before the capture stage sees them.
  always_comb begin
    cell_nxt    = cell_r;
    cell_nxt.s1 = pin_in_i;
    cell_nxt.s2 = cell_r.s1;
    cell_nxt.sh = sh_w;
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      cell_r <= '0;
    end else begin
      cell_r <= cell_nxt;
    end
  end

  // Update latches move on the falling edge so they never glitch mid-shift.
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      upd_r <= '0;
    end else if (update_i) begin
      upd_r <= cell_r.sh;
    end
  end

  assign so_o  = cell_r.sh[0];
  assign upd_o = upd_r;

endmodule : bst_bsr_chain

// ### rtl/bst_tap.sv
// Boundary-scan test access port: TAP controller, IR and data registers.
`timescale 1ns/1ns
`include "bst_cfg.svh"
module bst_tap
  import bst_pkg::*;
#(
  parameter int          BSR_LEN   = `BST_BSR_LEN,
  parameter logic [3:0]  ID_VER    = 4'h0,       // Arbitrary value.
  parameter logic [15:0] ID_PART   = 16'h5A5A,   // Arbitrary value.
  parameter logic [10:0] ID_MAKER  = 11'h015     // Arbitrary value.
) (
  input  wire logic               clk_sys_i,   // System clock, 100 MHz.
  input  wire logic               nrst_i,      // System reset, active low.
  input  wire logic               tck_i,       // Test clock.
  input  wire logic               trst_n_i,    // Test reset, active low.
  input  wire logic               tms_i,       // Test mode select.
  input  wire logic               tdi_i,       // Test data in.
  output logic                    tdo_o,       // Test data out.
  output logic                    tdo_oe_o,    // High while TDO is driven.
  input  wire logic [BSR_LEN-1:0] pin_in_i,    // Values seen at the port cells.
  input  wire logic [BSR_LEN-1:0] core_out_i,  // Functional output values.
  output logic      [BSR_LEN-1:0] pin_out_o,   // Values driven to the pins.
  output logic                    pin_oe_o,    // Output enable of all pins.
  output logic                    queue_run_o, // Queue function may run.
  output logic                    test_mode_o  // Test logic overrides the pins.
);

  // ********************
  // State types
  // ********************

  // State on the rising test clock.
  typedef struct packed {
    bst_state_type        state;
    logic [`BST_IR_W-1:0] ir_sh;
    logic                 byp;
    logic [`BST_ID_W-1:0] id_sh;
    logic                 reset_seen;
  } bst_tap_type;

  // State on the falling test clock.
  typedef struct packed {
    logic [`BST_IR_W-1:0] ir;
    logic                 tdo;
    logic                 tdo_oe;
  } bst_neg_type;

  // State on the system clock.
  typedef struct packed {
    logic [2:0]         ctl_s1;
    logic [2:0]         ctl_s2;
    logic [BSR_LEN-1:0] upd_s1;
    logic [BSR_LEN-1:0] upd_s2;
    logic [BSR_LEN-1:0] pin_out;
    logic               pin_oe;
    logic               queue_run;
    logic               test_mode;
  } bst_sys_type;

  bst_tap_type        tap_r;
  bst_tap_type        tap_nxt;
  bst_neg_type        neg_r;
  bst_neg_type        neg_nxt;
  bst_sys_type        sys_r;
  bst_sys_type        sys_nxt;
  bst_dr_type         dr_sel;
  logic               bsr_so;
  logic [BSR_LEN-1:0] bsr_upd;
  logic               in_tlr;
  logic               in_cdr;
  logic               in_shdr;
  logic               in_udr;
  logic               in_shir;
  logic               op_extest;
  logic               op_highz;
  logic [2:0]         ctl_tck;

  // ********************
  // Instruction decode
  // ********************

  // Unassigned codes fall to bypass, so a stray code never disturbs the queue.
  function automatic bst_dr_type bst_decode(input logic [`BST_IR_W-1:0] op);
    bst_dr_type sel;
    sel = BST_DR_BYP;
    if (op == `BST_OP_EXTEST || op == `BST_OP_SAMPLE) begin
      sel = BST_DR_BSR;
    end else if (op == `BST_OP_IDCODE) begin
      sel = BST_DR_ID;
    end else begin
      sel = BST_DR_BYP;
    end
    return sel;
  endfunction : bst_decode

  // TAP state walk; each branch depends only on the sampled TMS level.
  function automatic bst_state_type bst_next(input bst_state_type st, input logic tms);
    bst_state_type nx;
    nx = st;
    case (st)
      BST_TLR:  nx = tms ? BST_TLR  : BST_RTI;
      BST_RTI:  nx = tms ? BST_SDR  : BST_RTI;
      BST_SDR:  nx = tms ? BST_SIR  : BST_CDR;
      BST_CDR:  nx = tms ? BST_E1DR : BST_SHDR;
      BST_SHDR: nx = tms ? BST_E1DR : BST_SHDR;
      BST_E1DR: nx = tms ? BST_UDR  : BST_PDR;
      BST_PDR:  nx = tms ? BST_E2DR : BST_PDR;
      BST_E2DR: nx = tms ? BST_UDR  : BST_SHDR;
      BST_UDR:  nx = tms ? BST_SDR  : BST_RTI;
      BST_SIR:  nx = tms ? BST_TLR  : BST_CIR;
      BST_CIR:  nx = tms ? BST_E1IR : BST_SHIR;
      BST_SHIR: nx = tms ? BST_E1IR : BST_SHIR;
      BST_E1IR: nx = tms ? BST_UIR  : BST_PIR;
      BST_PIR:  nx = tms ? BST_E2IR : BST_PIR;
      BST_E2IR: nx = tms ? BST_UIR  : BST_SHIR;
      BST_UIR:  nx = tms ? BST_SDR  : BST_RTI;
      default:  nx = BST_TLR;
    endcase
    return nx;
  endfunction : bst_next

  // State flags used by both test clock edges.
  assign in_tlr  = (tap_r.state == BST_TLR);
  assign in_cdr  = (tap_r.state == BST_CDR);
  assign in_shdr = (tap_r.state == BST_SHDR);
  assign in_udr  = (tap_r.state == BST_UDR);
  assign in_shir = (tap_r.state == BST_SHIR);

  // The active instruction picks one of the parallel data registers.
  assign dr_sel = bst_decode(neg_r.ir);

  // ********************
  // Boundary chain
  // ********************

  // Only the selected register moves; the others keep still.
  bst_bsr_chain #(
    .LEN       (BSR_LEN)
  ) u_bsr (
    .tck_i     (tck_i),
    .trst_n_i  (trst_n_i),
    .capture_i (in_cdr && dr_sel == BST_DR_BSR),
    .shift_i   (in_shdr && dr_sel == BST_DR_BSR),
    .update_i  (in_udr && dr_sel == BST_DR_BSR),
    .tdi_i     (tdi_i),
    .pin_in_i  (pin_in_i),
    .so_o      (bsr_so),
    .upd_o     (bsr_upd)
  );

  // ********************
  // Rising edge logic
  // ********************

  // Controller, IR shift stages, bypass and ID shift stages.
  always_comb begin
    tap_nxt       = tap_r;
    tap_nxt.state = bst_next(tap_r.state, tms_i);
    // Reaching reset proves the tester has initialised the port.
    if (in_tlr) begin
      tap_nxt.reset_seen = 1'b1;
    end
    // Instruction shift stages; pause and exit states hold them.
    if (tap_r.state == BST_CIR) begin
      tap_nxt.ir_sh = `BST_IR_CAPT;
    end else if (in_shir) begin
      tap_nxt.ir_sh = {tdi_i, tap_r.ir_sh[`BST_IR_W-1:1]};
    end
    // Data registers load on capture and shift only when selected.
    if (in_cdr && dr_sel == BST_DR_BYP) begin
      tap_nxt.byp = 1'b0;
    end else if (in_shdr && dr_sel == BST_DR_BYP) begin
      tap_nxt.byp = tdi_i;
    end
    if (in_cdr && dr_sel == BST_DR_ID) begin
      tap_nxt.id_sh = {ID_VER, ID_PART, ID_MAKER, 1'b1};
    end else if (in_shdr && dr_sel == BST_DR_ID) begin
      tap_nxt.id_sh = {tdi_i, tap_r.id_sh[`BST_ID_W-1:1]};
    end
  end

  // Test reset puts the controller straight into test-logic-reset.
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tap_r            <= '0;
      tap_r.state      <= BST_TLR;
      tap_r.reset_seen <= 1'b1;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  // ********************
  // Falling edge logic
  // ********************

  // Instruction latch and TDO; TDO changes away from the tester's sample edge.
  always_comb begin
    neg_nxt        = neg_r;
    neg_nxt.tdo    = 1'b0;
    neg_nxt.tdo_oe = 1'b0;
    if (in_tlr) begin
      neg_nxt.ir = `BST_IR_RST;
    end else if (tap_r.state == BST_UIR) begin
      neg_nxt.ir = tap_r.ir_sh;
    end
    if (in_shir) begin
      neg_nxt.tdo    = tap_r.ir_sh[0];
      neg_nxt.tdo_oe = 1'b1;
    end else if (in_shdr) begin
      neg_nxt.tdo_oe = 1'b1;
      case (dr_sel)
        BST_DR_BSR: neg_nxt.tdo = bsr_so;
        BST_DR_ID:  neg_nxt.tdo = tap_r.id_sh[0];
        default:    neg_nxt.tdo = tap_r.byp;
      endcase
    end
  end

  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      neg_r    <= '0;
      neg_r.ir <= `BST_IR_RST;
    end else begin
      neg_r <= neg_nxt;
    end
  end

  assign tdo_o    = neg_r.tdo;
  assign tdo_oe_o = neg_r.tdo_oe;

  // ********************
  // Control levels
  // ********************

  // Only the external test and high-impedance codes touch the pins;
  // run-test-idle starts no self test, so nothing else comes alive there.
  assign op_extest = (neg_r.ir == `BST_OP_EXTEST);
  assign op_highz  = (neg_r.ir == `BST_OP_HIGHZ);
  assign ctl_tck   = {tap_r.reset_seen, op_highz, op_extest};

  // ********************
  // System clock logic
  // ********************

  // Levels and update latches cross by two flops each. The update bits are
  // only stable outside update-DR, so a tester must let the pins settle for
  // a few system clocks before sampling them in external test.
  always_comb begin
    sys_nxt        = sys_r;
    sys_nxt.ctl_s1 = ctl_tck;
    sys_nxt.ctl_s2 = sys_r.ctl_s1;
    sys_nxt.upd_s1 = bsr_upd;
    sys_nxt.upd_s2 = sys_r.upd_s1;
    // External test drives the update latches out in place of the core.
    if (sys_r.ctl_s2[0]) begin
      sys_nxt.pin_out = sys_r.upd_s2;
    end else begin
      sys_nxt.pin_out = core_out_i;
    end
    sys_nxt.pin_oe    = !sys_r.ctl_s2[1];
    sys_nxt.test_mode = sys_r.ctl_s2[0] || sys_r.ctl_s2[1];
    // Queue runs once the port was reset and no test owns the pins.
    sys_nxt.queue_run = sys_r.ctl_s2[2] && !sys_r.ctl_s2[0] && !sys_r.ctl_s2[1];
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_r <= '0;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign pin_out_o   = sys_r.pin_out;
  assign pin_oe_o    = sys_r.pin_oe;
  assign queue_run_o = sys_r.queue_run;
  assign test_mode_o = sys_r.test_mode;

endmodule : bst_tap

// ### verif/bst_tap_assertions.sv
// Concurrent checks on the ports of the boundary-scan test access port.
`timescale 1ns/1ns
module bst_tap_assertions #(
  parameter int BSR_LEN = 8
) (
  input  wire logic               clk_sys_i,   // System clock.
  input  wire logic               nrst_i,      // System reset, active low.
  input  wire logic               tck_i,       // Test clock.
  input  wire logic               trst_n_i,    // Test reset, active low.
  input  wire logic               tms_i,       // Test mode select.
  input  wire logic               tdo_o,       // Test data out.
  input  wire logic               tdo_oe_o,    // Test data out enable.
  input  wire logic [BSR_LEN-1:0] core_out_i,  // Functional output values.
  input  wire logic [BSR_LEN-1:0] pin_out_o,   // Values driven to the pins.
  input  wire logic               pin_oe_o,    // Pin output enable.
  input  wire logic               queue_run_o, // Queue function may run.
  input  wire logic               test_mode_o  // Test logic overrides pins.
);
  // ****************************************
  // Helper logic and sequences
  // ****************************************
  logic [1:0] age_r;

  // System outputs mean nothing until the synchroniser has refilled after reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end

  sequence s_to_tlr;
    tms_i [*5];
  endsequence
  sequence s_to_shdr;
    s_to_tlr ##1 !tms_i ##1 tms_i ##1 !tms_i ##1 !tms_i;
  endsequence
  sequence s_to_shir;
    s_to_tlr ##1 !tms_i ##1 tms_i ##1 tms_i ##1 !tms_i ##1 !tms_i;
  endsequence

  chk_tdo_quiet: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    !tdo_oe_o |-> !tdo_o) else $error("TDO not low while undriven");
  chk_reset_idcode: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    s_to_shdr |=> tdo_oe_o && tdo_o) else $error("No ID bit after TMS reset");
  chk_ir_capture: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    s_to_shir |=> tdo_oe_o && tdo_o ##1 !tdo_o) else $error("IR capture wrong");
  // Shift is entered from capture (TMS 1,0,0) or from exit2 after a pause (TMS 0,1,0).
  chk_shift_entry: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    $rose(tdo_oe_o) |-> !$past(tms_i) && $past(tms_i, 2) != $past(tms_i, 3))
    else $error("Shift entered wrongly");
  chk_shift_exit: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tdo_oe_o && tms_i |=> !tdo_oe_o) else $error("Shift not left on TMS high");
  chk_trst_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !trst_n_i |-> !tdo_oe_o) else $error("TDO driven in test reset");
  chk_mode_excl: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    age_r == 2'h3 && test_mode_o |-> !queue_run_o) else $error("Queue runs in test mode");
  chk_highz_mode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    age_r == 2'h3 && !pin_oe_o |-> test_mode_o) else $error("Pins off outside test mode");
  chk_pin_follow: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    age_r == 2'h3 && !test_mode_o && $past(!test_mode_o) && $past(!test_mode_o, 2)
    |-> pin_out_o == $past(core_out_i)) else $error("Pins do not follow core");
endmodule : bst_tap_assertions

bind bst_tap bst_tap_assertions #(.BSR_LEN(BSR_LEN)) u_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tck_i(tck_i), .trst_n_i(trst_n_i),
  .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .core_out_i(core_out_i),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .queue_run_o(queue_run_o),
  .test_mode_o(test_mode_o));

// ### verif/bst_tester.sv
// Tester model: drives the test clock, reset, mode and data pins.
`timescale 1ns/1ns
module bst_tester (
  output logic      tck_o,    // Test clock, still between frames.
  output logic      trst_n_o, // Test reset, active low.
  output logic      tms_o,    // Test mode select.
  output logic      tdi_o,    // Serial data to the port.
  input  wire logic tdo_i     // Serial data from the port.
);
  // ****************************************
  // Link tasks
  // ****************************************
  initial begin
    tck_o = 1'b0;
    // Test reset stays released at power-up, so the port wakes undefined
    // until reset_tap gives it a clean falling edge.
    trst_n_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One 64 ns period; pins move while the clock is low, TDO is read at the rise.
  task automatic step(input logic t, input logic d, output logic o);
    tms_o = t;
    tdi_o = d;
    #32;
    o = tdo_i;
    tck_o = 1'b1;
    #32;
    tck_o = 1'b0;
  endtask : step

  // Idle data line toggles so a stale level is never mistaken for data.
  task automatic go(input logic t);
    logic o;
    step(t, ~tdi_o, o);
  endtask : go

  // The port does not reset itself, so the tester pulses test reset first.
  task automatic reset_tap;
    trst_n_o = 1'b0;
    #100;
    trst_n_o = 1'b1;
    #64;
  endtask : reset_tap

  // Five clocks with TMS high, then park in run-test-idle.
  task automatic tlr;
    repeat (5) go(1'b1);
    go(1'b0);
  endtask : tlr

  // Scan n bits LSB first from run-test-idle; pause once after bit pz.
  task automatic scan(input logic ir, input int n, input int pz,
                      input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = 32'h0000_0000;
    go(1'b1);
    if (ir) go(1'b1);
    go(1'b0);
    go(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz, din[i], b);
      dout[i] = b;
      if (i == pz && i != n - 1) begin
        go(1'b0);
        go(1'b0);
        go(1'b1);
        go(1'b0);
      end
    end
    go(1'b1);
    go(1'b0);
  endtask : scan
endmodule : bst_tester

// ### verif/bst_tap_tb_top.sv
// Self-checking testbench of the boundary-scan test access port.
`timescale 1ns/1ns
module bst_tap_tb_top;
  // ****************************************
  // Bench signals and instances
  // ****************************************
  localparam logic [31:0] ID = {4'h3, 16'h1234, 11'h0AB, 1'b1}; // Arbitrary values.
  logic       clk_sys_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic [7:0] pin_in_i = 8'hC5;
  logic [7:0] core_out_i = 8'h3C;
  logic       tck, trst_n, tms, tdi, tdo, tdo_oe, pin_oe, queue_run, test_mode;
  logic [7:0] pin_out;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;

  bst_tap #(.BSR_LEN(8), .ID_VER(4'h3), .ID_PART(16'h1234), .ID_MAKER(11'h0AB)) u_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tck_i(tck), .trst_n_i(trst_n), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in_i), .core_out_i(core_out_i),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .queue_run_o(queue_run), .test_mode_o(test_mode));
  bst_tester u_tester (.tck_o(tck), .trst_n_o(trst_n), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

  always #5 clk_sys_i = ~clk_sys_i;

  // A hung scan is cut off well beyond the few thousand cycles the run needs.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // ****************************************
  // Scenarios
  // ****************************************
  // Identification read with a pause in mid-scan.
  task automatic t_idcode;
    logic [31:0] o;
    u_tester.tlr;
    u_tester.scan(1'b0, 32, 5, 32'hF0F0_1234, o);
    chk("idcode", ID, o);
  endtask : t_idcode

  // Every assigned code plus two unassigned ones: path and pin effects.
  task automatic t_codes;
    logic [3:0]  codes [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF, 4'h3, 4'h9};
    logic [31:0] o, e, d;
    logic [7:0]  pe;
    logic        tst;
    foreach (codes[k]) begin
      d = 32'hA5C3_0F96 ^ {8{codes[k]}};
      tst = codes[k] == 4'h0 || codes[k] == 4'h4;
      @(posedge clk_sys_i) core_out_i <= {codes[k], ~codes[k]};
      u_tester.tlr;
      u_tester.scan(1'b1, 4, 99, {28'h000_0000, codes[k]}, o);
      chk("ir capture", 32'h0000_0001, {28'h000_0000, o[3:0]});
      u_tester.scan(1'b0, 32, 99, d, o);
      case (codes[k])
        4'h0, 4'h1: e = {d[23:0], pin_in_i};
        4'h2:       e = ID;
        default:    e = {d[30:0], 1'b0};
      endcase
      chk("dr scan", e, o);
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("pin enable", 32'(codes[k] != 4'h4), 32'(pin_oe));
      chk("test mode", 32'(tst), 32'(test_mode));
      chk("queue run", 32'(!tst), 32'(queue_run));
      pe = codes[k] == 4'h0 ? d[31:24] : {codes[k], ~codes[k]};
      chk("pin out", 32'(pe), 32'(pin_out));
    end
  endtask : t_codes

  // TMS-only reset out of high impedance, then a system reset in mid-run.
  task automatic t_tms_reset;
    logic [31:0] o;
    u_tester.tlr;
    u_tester.scan(1'b1, 4, 99, 32'h0000_0004, o);
    u_tester.tlr;
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("released pins", 32'h0000_0001, 32'(pin_oe));
    u_tester.scan(1'b0, 32, 99, 32'h0000_0000, o);
    chk("idcode after reset", ID, o);
    @(posedge clk_sys_i) nrst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("queue held", 32'h0000_0000, 32'(queue_run));
    chk("pins held", 32'h0000_0000, 32'(pin_oe));
    @(posedge clk_sys_i) nrst_i <= 1'b1;
    // The crossing refills in two edges; the third edge shows the levels again.
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("queue resumed", 32'h0000_0001, 32'(queue_run));
    chk("pins resumed", 32'h0000_0001, 32'(pin_oe));
  endtask : t_tms_reset

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    u_tester.reset_tap;
    t_idcode;
    t_codes;
    t_tms_reset;
    end_of_test;
  end
endmodule : bst_tap_tb_top
